/* design/thermal_alarm_watchdog.sv */
// Temperature result, set-point compare and alarm pin of the thermal watchdog.
// Assumes an outer framer raising i_frame for one bus transaction (start to
// stop) and the bus clock as i_scl; the converter supplies a result at all times.
`timescale 1ns/1ps
module thermal_alarm_watchdog #(
  parameter int CONV_CYCLES = thermal_alarm_pkg::CONV_CYCLES,
  parameter logic [6:0] DEV_ADDR = 7'h48
) (
  // System
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // Converter
  input wire logic [10:0] i_adc_result,
  // Serial link
  input wire logic i_scl,
  input wire logic i_frame,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  // Alarm pin
  output logic o_alarm_out,
  output logic o_alarm_oe
);
  import thermal_alarm_pkg::*;

  localparam int CNT_W = $clog2(CONV_CYCLES);
  localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYCLES - 1);

  function automatic logic [15:0] word_of(input reg_snap_t s, input logic [1:0] p);
    if (p == PTR_TEMP) begin
      word_of = {s.temp, {TEMP_PAD{1'b0}}};
    end else if (p == PTR_CONF) begin
      word_of = {s.conf, 8'h00};
    end else if (p == PTR_RELEASE) begin
      word_of = {s.release_lim, {SETPOINT_PAD{1'b0}}};
    end else begin
      word_of = {s.upper, {SETPOINT_PAD{1'b0}}};
    end
  endfunction

  // ----------------------------------------------------------------
  // Link domain
  // ----------------------------------------------------------------
  typedef enum {L_ADDR, L_PTR, L_WDATA, L_RDATA, L_IGNORE} link_state_t;

  // Framer ends every transaction; link state must not outlive a frame
  logic link_rst_n;
  assign link_rst_n = i_resetn & i_frame;

  link_state_t lstate_reg;
  logic [3:0] bit_cnt_reg;
  logic [6:0] shift_reg;
  logic byte_idx_reg;
  logic ack_en_reg;
  logic [1:0] ptr_reg;
  logic [7:0] wr_hi_reg;
  wr_pkt_t wr_pkt_reg;
  logic wr_tgl_reg;
  logic rd_tgl_reg;
  logic [SYNC_DEPTH-1:0] snap_sync_reg;
  logic snap_ack_reg;
  reg_snap_t snap_link_reg;
  logic snap_tgl_reg;
  reg_snap_t snap_pub_reg;
  logic sda_oe_reg;
  logic [7:0] rx_byte;
  logic [15:0] rd_word;
  logic [3:0] tx_idx;

  assign rx_byte = {shift_reg, i_sda};
  assign rd_word = word_of(snap_link_reg, ptr_reg);
  assign tx_idx = {byte_idx_reg, 3'h7 - bit_cnt_reg[2:0]};

  // Bit and byte sequencing, sampled on the rising bus clock
  always_ff @(posedge i_scl or negedge link_rst_n) begin
    if (!link_rst_n) begin
      lstate_reg <= L_ADDR;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 7'h00;
      byte_idx_reg <= 1'b0;
      ack_en_reg <= 1'b0;
    end else if (bit_cnt_reg == 4'h8) begin
      bit_cnt_reg <= 4'h0;
      if (lstate_reg == L_RDATA) begin
        if (i_sda) begin
          lstate_reg <= L_IGNORE;
        end else begin
          byte_idx_reg <= ~byte_idx_reg;
        end
      end
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
      shift_reg <= rx_byte[6:0];
      if (bit_cnt_reg == 4'h7) begin
        ack_en_reg <= 1'b0;
        case (lstate_reg)
          L_ADDR: begin
            if (rx_byte[7:1] == DEV_ADDR) begin
              ack_en_reg <= 1'b1;
              // Pre-set so the address ack slot flips it to the high byte
              byte_idx_reg <= 1'b0;
              lstate_reg <= rx_byte[0] ? L_RDATA : L_PTR;
            end else begin
              lstate_reg <= L_IGNORE;
            end
          end
          L_PTR: begin
            ack_en_reg <= 1'b1;
            byte_idx_reg <= 1'b0;
            lstate_reg <= L_WDATA;
          end
          L_WDATA: begin
            ack_en_reg <= 1'b1;
            byte_idx_reg <= 1'b1;
          end
          default: begin
            ack_en_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  // Pointer, write packets and read events survive the frame
  always_ff @(posedge i_scl or negedge i_resetn) begin
    if (!i_resetn) begin
      ptr_reg <= PTR_RST;
      wr_hi_reg <= 8'h00;
      wr_pkt_reg <= '0;
      wr_tgl_reg <= 1'b0;
      rd_tgl_reg <= 1'b0;
    end else if (i_frame && bit_cnt_reg == 4'h7) begin
      if (lstate_reg == L_ADDR && rx_byte[7:1] == DEV_ADDR && rx_byte[0]) begin
        rd_tgl_reg <= ~rd_tgl_reg;
      end else if (lstate_reg == L_PTR) begin
        ptr_reg <= rx_byte[1:0];
      end else if (lstate_reg == L_WDATA && !byte_idx_reg) begin
        wr_hi_reg <= rx_byte;
        if (ptr_reg == PTR_CONF) begin
          wr_pkt_reg <= '{ptr: ptr_reg, data: {rx_byte, 8'h00}};
          wr_tgl_reg <= ~wr_tgl_reg;
        end
      end else if (lstate_reg == L_WDATA && ptr_reg[1]) begin
        // Limits take effect only once both bytes have arrived
        wr_pkt_reg <= '{ptr: ptr_reg, data: {wr_hi_reg, rx_byte}};
        wr_tgl_reg <= ~wr_tgl_reg;
      end
    end
  end

  // Register snapshot taken over from the system side
  always_ff @(posedge i_scl or negedge i_resetn) begin
    if (!i_resetn) begin
      snap_sync_reg <= '0;
      snap_ack_reg <= 1'b0;
      snap_link_reg <= '{conf: CONF_RST, upper: UPPER_RST, release_lim: RELEASE_RST,
                         temp: TEMP_RST};
    end else begin
      snap_sync_reg <= {snap_sync_reg[SYNC_DEPTH-2:0], snap_tgl_reg};
      if (snap_sync_reg[1] == snap_sync_reg[2] && snap_sync_reg[2] != snap_ack_reg) begin
        snap_ack_reg <= snap_sync_reg[2];
        snap_link_reg <= snap_pub_reg;
      end
    end
  end

  // Data line changes only while the bus clock is low
  always_ff @(negedge i_scl or negedge link_rst_n) begin
    if (!link_rst_n) begin
      sda_oe_reg <= 1'b0;
    end else if (bit_cnt_reg == 4'h8) begin
      sda_oe_reg <= ack_en_reg;
    end else if (lstate_reg == L_RDATA) begin
      sda_oe_reg <= ~rd_word[tx_idx];
    end else begin
      sda_oe_reg <= 1'b0;
    end
  end

  assign o_sda = 1'b0;
  assign o_sda_oe = sda_oe_reg;

  // ----------------------------------------------------------------
  // System domain: crossings
  // ----------------------------------------------------------------
  logic [SYNC_DEPTH-1:0] wr_sync_reg;
  logic [SYNC_DEPTH-1:0] rd_sync_reg;
  logic [SYNC_DEPTH-1:0] ack_sync_reg;
  logic wr_seen_reg;
  logic rd_seen_reg;
  logic wr_evt;
  logic rd_evt;

  assign wr_evt = wr_sync_reg[1] == wr_sync_reg[2] && wr_sync_reg[2] != wr_seen_reg;
  assign rd_evt = rd_sync_reg[1] == rd_sync_reg[2] && rd_sync_reg[2] != rd_seen_reg;

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_sync_reg <= '0;
      rd_sync_reg <= '0;
      ack_sync_reg <= '0;
      wr_seen_reg <= 1'b0;
      rd_seen_reg <= 1'b0;
    end else begin
      wr_sync_reg <= {wr_sync_reg[SYNC_DEPTH-2:0], wr_tgl_reg};
      rd_sync_reg <= {rd_sync_reg[SYNC_DEPTH-2:0], rd_tgl_reg};
      ack_sync_reg <= {ack_sync_reg[SYNC_DEPTH-2:0], snap_ack_reg};
      wr_seen_reg <= wr_evt ? wr_sync_reg[2] : wr_seen_reg;
      rd_seen_reg <= rd_evt ? rd_sync_reg[2] : rd_seen_reg;
    end
  end

  // ----------------------------------------------------------------
  // System domain: registers
  // ----------------------------------------------------------------
  logic [7:0] conf_reg;
  logic [8:0] upper_reg;
  logic [8:0] release_reg;
  logic [10:0] temp_reg;

  // Reserved configuration bits are stored as written
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      conf_reg <= CONF_RST;
      upper_reg <= UPPER_RST;
      release_reg <= RELEASE_RST;
    end else if (wr_evt) begin
      if (wr_pkt_reg.ptr == PTR_CONF) begin
        conf_reg <= wr_pkt_reg.data[15:8];
      end else if (wr_pkt_reg.ptr == PTR_UPPER) begin
        upper_reg <= wr_pkt_reg.data[15:SETPOINT_PAD];
      end else if (wr_pkt_reg.ptr == PTR_RELEASE) begin
        release_reg <= wr_pkt_reg.data[15:SETPOINT_PAD];
      end
    end
  end

  // Republish as soon as the link has taken the last copy; the link
  // clock only runs in frames, so a read may see a slightly older copy.
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      snap_tgl_reg <= 1'b0;
      snap_pub_reg <= '{conf: CONF_RST, upper: UPPER_RST, release_lim: RELEASE_RST,
                        temp: TEMP_RST};
    end else if (ack_sync_reg[1] == ack_sync_reg[2] && ack_sync_reg[2] == snap_tgl_reg) begin
      snap_tgl_reg <= ~snap_tgl_reg;
      snap_pub_reg <= '{conf: conf_reg, upper: upper_reg, release_lim: release_reg,
                        temp: temp_reg};
    end
  end

  // ----------------------------------------------------------------
  // Conversion timebase
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] conv_cnt_reg;
  logic shutdown;
  logic conv_done;

  assign shutdown = conf_reg[CONF_SHUTDOWN_BIT];
  assign conv_done = !shutdown && conv_cnt_reg == CONV_LAST;

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      conv_cnt_reg <= '0;
      temp_reg <= TEMP_RST;
    end else if (!shutdown) begin
      conv_cnt_reg <= conv_done ? '0 : conv_cnt_reg + CNT_W'(1);
      if (conv_done) begin
        temp_reg <= i_adc_result;
      end
    end
  end

  // ----------------------------------------------------------------
  // Limit compare, fault queue and alarm
  // ----------------------------------------------------------------
  logic [8:0] new_cmp;
  logic above_upper;
  logic below_release;
  logic int_mode;
  logic trip;
  logic alarm_evt;
  logic [2:0] need;
  logic [2:0] fault_cnt_reg;
  logic seek_low_reg;
  logic alarm_reg;
  logic alarm_oe_reg;

  // Result is two's complement in eighth degrees; its top nine bits
  // are half-degree counts, the same scale as the limits.
  assign new_cmp = i_adc_result[10:TEMP_CMP_LSB];
  assign above_upper = $signed(new_cmp) > $signed(upper_reg);
  assign below_release = $signed(new_cmp) < $signed(release_reg);
  assign int_mode = conf_reg[CONF_MODE_BIT];
  assign need = fault_need(conf_reg[CONF_QUEUE_LSB+1:CONF_QUEUE_LSB]);
  assign trip = (int_mode ? seek_low_reg : alarm_reg) ? below_release : above_upper;
  assign alarm_evt = conv_done && trip && fault_cnt_reg + 3'h1 == need;

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      fault_cnt_reg <= 3'h0;
    end else if (conv_done) begin
      fault_cnt_reg <= (trip && !alarm_evt) ? fault_cnt_reg + 3'h1 : 3'h0;
    end
  end

  // An alarm_evt (a completed fault run) in the cycle of a read clearing wins over the clear
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      alarm_reg <= 1'b0;
      seek_low_reg <= 1'b0;
    end else if (alarm_evt) begin
      if (int_mode) begin
        alarm_reg <= 1'b1;
        seek_low_reg <= ~seek_low_reg;
      end else begin
        alarm_reg <= ~alarm_reg;
      end
    end else if (int_mode && rd_evt) begin
      alarm_reg <= 1'b0;
    end
  end

  // Open drain: pull low for a low level, release for high
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      alarm_oe_reg <= 1'b0;
    end else begin
      alarm_oe_reg <= alarm_reg ? !conf_reg[CONF_POL_BIT] : conf_reg[CONF_POL_BIT];
    end
  end

  assign o_alarm_out = 1'b0;
  assign o_alarm_oe = alarm_oe_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);

  chk_temp_pad: assert property (@(posedge i_scl) disable iff (!link_rst_n)
    ptr_reg == PTR_TEMP |-> rd_word[TEMP_PAD-1:0] == '0)
    else $error("result low bits not zero");
  chk_limit_pad: assert property (@(posedge i_scl) disable iff (!link_rst_n)
    ptr_reg[1] |-> rd_word[SETPOINT_PAD-1:0] == '0)
    else $error("limit low bits not zero");
  chk_temp_update: assert property (conv_done |=> temp_reg == $past(i_adc_result))
    else $error("result not taken at conversion end");
  chk_shutdown_halt: assert property (shutdown |-> !conv_done ##1 $stable(temp_reg))
    else $error("conversion during shutdown");
  chk_queue_run: assert property ($changed(alarm_reg) && !$past(rd_evt) |->
    $past(conv_done) && $past(fault_cnt_reg) + 3'h1 == $past(need))
    else $error("alarm moved without full fault run");
  chk_count_restart: assert property (conv_done && !trip |=> fault_cnt_reg == 3'h0)
    else $error("fault count not restarted");
  chk_comp_hold: assert property (!int_mode && !conv_done |=> $stable(alarm_reg))
    else $error("comparator alarm moved without conversion");
  chk_int_clear: assert property (int_mode && rd_evt && !alarm_evt |=> !alarm_reg)
    else $error("read did not clear interrupt alarm");
  chk_pin_level: assert property (##1 o_alarm_oe ==
    ($past(alarm_reg) ? !$past(conf_reg[CONF_POL_BIT]) : $past(conf_reg[CONF_POL_BIT])))
    else $error("alarm pin level wrong");

  cov_comp_alarm: cover property (!int_mode ##0 $rose(alarm_reg));
  cov_int_cleared: cover property (int_mode && alarm_reg ##1 rd_evt ##1 !alarm_reg);
  cov_shutdown: cover property ($rose(shutdown));
  cov_link_read: cover property (@(posedge i_scl) lstate_reg == L_RDATA && byte_idx_reg);

endmodule

/* design/thermal_alarm_pkg.sv */
// Constants, register layout and carriers of the thermal alarm watchdog.
// Assumes one system clock domain and one serial link clock domain.
package thermal_alarm_pkg;

  // ----------------------------------------------------------------
  // Register selection
  // ----------------------------------------------------------------
  localparam logic [1:0] PTR_TEMP = 2'h0;
  localparam logic [1:0] PTR_CONF = 2'h1;
  localparam logic [1:0] PTR_RELEASE = 2'h2;
  localparam logic [1:0] PTR_UPPER = 2'h3;
  localparam logic [1:0] PTR_RST = 2'h0;

  // ----------------------------------------------------------------
  // Configuration byte fields and reset values
  // ----------------------------------------------------------------
  localparam int CONF_SHUTDOWN_BIT = 0;
  localparam int CONF_MODE_BIT = 1;
  localparam int CONF_POL_BIT = 2;
  localparam int CONF_QUEUE_LSB = 3;
  localparam logic [7:0] CONF_RST = 8'h00;
  // 80 and 75 degrees in half-degree counts
  localparam logic [8:0] UPPER_RST = 9'h0a0;
  localparam logic [8:0] RELEASE_RST = 9'h096;
  localparam logic [10:0] TEMP_RST = 11'h000;

  // ----------------------------------------------------------------
  // Word layout on the link
  // ----------------------------------------------------------------
  localparam int TEMP_PAD = 5;
  localparam int SETPOINT_PAD = 7;
  localparam int TEMP_CMP_LSB = 2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_KHZ = 250000;
  localparam int CONV_TIME_MS = 100;
  localparam int CONV_CYCLES = CONV_TIME_MS * CLK_FREQ_KHZ;
  localparam int SYNC_DEPTH = 3;

  // ----------------------------------------------------------------
  // Carriers between the domains
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] conf;
    logic [8:0] upper;
    logic [8:0] release_lim;
    logic [10:0] temp;
  } reg_snap_t;

  typedef struct packed {
    logic [1:0] ptr;
    logic [15:0] data;
  } wr_pkt_t;

  function automatic logic [2:0] fault_need(input logic [1:0] sel);
    case (sel)
      2'h0: fault_need = 3'h1;
      2'h1: fault_need = 3'h2;
      2'h2: fault_need = 3'h4;
      default: fault_need = 3'h6;
    endcase
  endfunction

endpackage

/* verification/i2c_host_model.sv */
// Host on the watchdog's two-wire link: frames, bytes and acknowledges.
// Assumes the bench feeds o_sda to the device and the device's enable back.
`timescale 1ns/1ps
module i2c_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h48
) (
  // Device side
  input wire logic i_sda_oe,
  // Bus
  output logic o_scl,
  output logic o_frame,
  output logic o_sda
);
  logic pull;
  int nak;
  // Pull-up: a released line reads high, never the last value
  assign o_sda = ~(pull | i_sda_oe);
  initial begin
    pull = 1'b0;
    o_scl = 1'b0;
    o_frame = 1'b0;
    nak = 0;
  end
  // ----------------------------------------
  // Bit and byte level
  // ----------------------------------------
  // Data changes only while the link clock is low
  task automatic bit_x(input logic b, output logic r);
    pull = ~b;
    #24 o_scl = 1'b1;
    r = o_sda;
    #24 o_scl = 1'b0;
  endtask
  task automatic byte_out(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
    end
    bit_x(1'b1, r);
    if (r !== 1'b0) begin
      nak++;
    end
  endtask
  task automatic byte_in(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, d[i]);
    end
    bit_x(last, r);
  endtask
  // ----------------------------------------
  // Frames
  // ----------------------------------------
  // Link clock stands still low outside frames
  task automatic open_frame();
    #13 o_frame = 1'b1;
    #24;
  endtask
  task automatic close_frame();
    pull = 1'b0;
    #24 o_frame = 1'b0;
    #37;
  endtask
  task automatic write_reg(input logic [1:0] ptr, input logic [15:0] d, input int n);
    open_frame();
    byte_out({DEV_ADDR, 1'b0});
    byte_out({6'h00, ptr});
    if (n > 0) begin
      byte_out(d[15:8]);
    end
    if (n > 1) begin
      byte_out(d[7:0]);
    end
    close_frame();
  endtask
  // Clocks in the high byte, and the low byte only when n is above 1; the last one gets no acknowledge
  task automatic read_reg(input int n, output logic [15:0] d);
    open_frame();
    byte_out({DEV_ADDR, 1'b1});
    byte_in(n == 1, d[15:8]);
    d[7:0] = 8'h00;
    if (n > 1) begin
      byte_in(1'b1, d[7:0]);
    end
    close_frame();
  endtask
endmodule

/* verification/tb.sv */
// Self-checking bench for the thermal alarm watchdog.
// Assumes the host model on the link; the converter result is bench-driven.
`timescale 1ns/1ps
module tb;
  import thermal_alarm_pkg::*;
  localparam int CONV = 64;
  typedef struct packed {
    logic [10:0] adc;
    logic [15:0] word;
    logic alarm;
  } row_t;
  logic i_clk_sys;
  logic i_resetn;
  logic [10:0] i_adc_result;
  logic scl;
  logic frame;
  logic sda;
  logic sda_oe;
  logic alarm_oe;
  logic sda_lvl;
  logic alarm_lvl;
  logic [15:0] rd;
  int err_total;
  int comparisons;
  int cyc;
  int need [4] = '{1, 2, 4, 6};
  row_t rows [7] = '{'{11'h3f8, 16'h7f00, 1'b1}, '{11'h001, 16'h0020, 1'b0},
    '{11'h3f7, 16'h7ee0, 1'b1}, '{11'h000, 16'h0000, 1'b0}, '{11'h7ff, 16'hffe0, 1'b0},
    '{11'h649, 16'hc920, 1'b0}, '{11'h738, 16'he700, 1'b0}};

  thermal_alarm_watchdog #(.CONV_CYCLES(CONV)) i_dut (
    .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_adc_result(i_adc_result),
    .i_scl(scl), .i_frame(frame), .i_sda(sda), .o_sda(sda_lvl), .o_sda_oe(sda_oe),
    .o_alarm_out(alarm_lvl), .o_alarm_oe(alarm_oe));
  i2c_host_model i_host (.i_sda_oe(sda_oe), .o_scl(scl), .o_frame(frame), .o_sda(sda));

  initial begin
    i_clk_sys = 1'b0;
    forever #2 i_clk_sys = ~i_clk_sys;
  end
  // Conversion phase; the timebase pauses in shutdown, so this does too
  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      cyc <= 0;
    end else if (!i_dut.shutdown) begin
      cyc <= cyc + 1;
    end
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Pin pulled low when active-low alarm is on or active-high alarm is off
  task automatic pin(input logic active, input logic pol);
    check("alarm_oe", {15'h0, alarm_oe}, {15'h0, active ^ pol});
  endtask
  // Mid-conversion so inputs never change near a compare
  task automatic convs(input int n);
    int w;
    repeat (n) begin
      w = 0;
      @(negedge i_clk_sys);
      while (cyc % CONV != CONV / 2 && w < 2 * CONV) begin
        w++;
        @(negedge i_clk_sys);
      end
      if (w >= 2 * CONV) begin
        err_total++;
        summarize();
      end
    end
  endtask
  task automatic rdp(input logic [1:0] p, input int n);
    i_host.write_reg(p, 16'h0000, 0);
    i_host.read_reg(n, rd);
  endtask
  task automatic defaults();
    rdp(PTR_CONF, 1);
    check("conf", rd, 16'h0000);
    rdp(PTR_RELEASE, 2);
    check("release", rd, 16'h4b00);
    rdp(PTR_UPPER, 2);
    check("upper", rd, 16'h5000);
  endtask
  task automatic summarize();
    if (err_total == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #200us;
    err_total++;
    summarize();
  end
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    err_total = 0;
    comparisons = 0;
    i_resetn = 1'b0;
    i_adc_result = 11'h0c8;
    repeat (3) @(negedge i_clk_sys);
    i_resetn = 1'b1;
    convs(2);
    pin(1'b0, 1'b0);
    i_host.read_reg(2, rd);
    check("temp_ptr0", rd, 16'h1900);
    defaults();
    foreach (rows[k]) begin
      convs(1);
      i_adc_result = rows[k].adc;
      convs(2);
      pin(rows[k].alarm, 1'b0);
      rdp(PTR_TEMP, 2);
      check("temp", rd, rows[k].word);
    end
    i_host.write_reg(PTR_TEMP, 16'h1234, 2);
    i_host.read_reg(2, rd);
    check("temp_ro", rd, 16'he700);
    // Upper 26.0, release 24.5; upper kept above release
    i_host.write_reg(PTR_UPPER, 16'h1a7f, 2);
    i_host.write_reg(PTR_RELEASE, 16'h18ff, 2);
    rdp(PTR_UPPER, 2);
    check("upper_wr", rd, 16'h1a00);
    rdp(PTR_RELEASE, 2);
    check("release_wr", rd, 16'h1880);
    convs(1);
    i_adc_result = 11'h0d3;
    convs(3);
    pin(1'b0, 1'b0);
    for (int q = 0; q < 4; q++) begin
      i_host.write_reg(PTR_CONF, {3'h0, q[1:0], 3'h0, 8'h00}, 1);
      convs(1);
      i_adc_result = 11'h0d4;
      convs(need[q] - 1);
      pin(1'b0, 1'b0);
      convs(1);
      pin(1'b1, 1'b0);
      i_adc_result = 11'h0c0;
      convs(6);
      pin(1'b0, 1'b0);
    end
    i_adc_result = 11'h0d4;
    convs(5);
    i_adc_result = 11'h0c8;
    convs(1);
    i_adc_result = 11'h0d4;
    convs(5);
    pin(1'b0, 1'b0);
    convs(1);
    pin(1'b1, 1'b0);
    rdp(PTR_TEMP, 2);
    check("temp_live", rd, 16'h1a80);
    pin(1'b1, 1'b0);
    i_host.write_reg(PTR_CONF, 16'h1900, 1);
    repeat (CONV) @(negedge i_clk_sys);
    i_adc_result = 11'h0b0;
    repeat (8 * CONV) @(negedge i_clk_sys);
    pin(1'b1, 1'b0);
    i_host.write_reg(PTR_RELEASE, 16'h1800, 2);
    rdp(PTR_RELEASE, 2);
    check("release_sd", rd, 16'h1800);
    rdp(PTR_TEMP, 2);
    check("temp_sd", rd, 16'h1a80);
    i_host.write_reg(PTR_CONF, 16'h1800, 1);
    repeat (8 * CONV) @(negedge i_clk_sys);
    pin(1'b0, 1'b0);
    // Interrupt mode, active-high, one fault
    i_host.write_reg(PTR_CONF, 16'h0600, 1);
    rdp(PTR_CONF, 1);
    check("conf_rb", rd, 16'h0600);
    convs(2);
    pin(1'b0, 1'b1);
    i_adc_result = 11'h0d4;
    convs(1);
    pin(1'b1, 1'b1);
    i_adc_result = 11'h0c8;
    convs(2);
    pin(1'b1, 1'b1);
    i_host.read_reg(1, rd);
    convs(1);
    pin(1'b0, 1'b1);
    i_adc_result = 11'h0b0;
    convs(1);
    pin(1'b1, 1'b1);
    i_host.read_reg(1, rd);
    convs(1);
    pin(1'b0, 1'b1);
    i_resetn = 1'b0;
    repeat (3) @(negedge i_clk_sys);
    i_resetn = 1'b1;
    convs(2);
    pin(1'b0, 1'b0);
    i_host.read_reg(2, rd);
    check("temp_rst", rd, 16'h1600);
    defaults();
    check("nak", 16'(i_host.nak), 16'h0000);
    check("pin_drive", {14'h0, sda_lvl, alarm_lvl}, 16'h0000);
    summarize();
  end
endmodule
